// ==== logic/cfps_pkg.sv ====
// Package for the charger fault protection sequencer.
// Assumes a 50 MHz clock; comparator flags arrive asynchronously.
package cfps_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 50;
    localparam int HOLDOFF_US       = 1000;
    localparam int HOLDOFF_CYCLES   = HOLDOFF_US * CLK_MHZ;
    localparam int BLANK_NS         = 100;
    localparam int BLANK_CYCLES     = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int SOFTSTART_US     = 10;
    localparam int SOFTSTART_CYCLES = SOFTSTART_US * CLK_MHZ;
    localparam int REFRESH_NS       = 200;
    localparam int REFRESH_CYCLES   = (REFRESH_NS * CLK_MHZ + 999) / 1000;
    // ------------------------------------------------------------
    // Option register fields
    // ------------------------------------------------------------
    localparam int OPT_HS_THR_LO   = 7;
    localparam int OPT_HS_THR_HI   = 8;
    localparam int OPT_FREQ_EN     = 9;
    localparam int OPT_FREQ_UP     = 10;
    localparam int OPT_WIDTH       = 16;
    // ------------------------------------------------------------
    // Short counting
    // ------------------------------------------------------------
    localparam logic [2:0] SHORT_LIMIT = 3'h7;
    localparam logic [1:0] LS_THR_CODE = 2'h0;
    // Frequency trim codes: 0 nominal, 1 lowered, 2 raised
    localparam logic [1:0] FREQ_NOM  = 2'h0;
    localparam logic [1:0] FREQ_DOWN = 2'h1;
    localparam logic [1:0] FREQ_UP   = 2'h2;
    localparam int FREQ_SHIFT_PCT    = 18;

    typedef enum logic [2:0] {
        CFPS_OFF      = 3'b000,
        CFPS_SOFT     = 3'b001,
        CFPS_RUN      = 3'b010,
        CFPS_HOLDOFF  = 3'b011,
        CFPS_THERMAL  = 3'b100,
        CFPS_LATCHED  = 3'b101
    } cfps_state_t;
endpackage

// ==== logic/cfps_short_counter.sv ====
// One blanked short-event counter.
// Assumes a synchronised comparator flag and a switch-on level.
`timescale 1ns/100ps
module cfps_short_counter (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       clear,
    // Switch and comparator
    input  wire logic       switchOn,
    input  wire logic       shortFlag,
    // Result
    output logic [2:0]      count
);
    import cfps_pkg::*;

    logic [7:0] blankCnt;
    logic       prevOn;
    logic       armed;
    logic       eventSeen;

    // ------------------------------------------------------------
    // Blanking after each turn-on
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prevOn    <= 1'b0;
            blankCnt  <= 8'h00;
            armed     <= 1'b0;
            eventSeen <= 1'b0;
        end else begin
            prevOn <= switchOn;
            if (switchOn && !prevOn) begin
                blankCnt  <= 8'h00;
                armed     <= 1'b0;
                eventSeen <= 1'b0;
            end else if (switchOn && !armed) begin
                blankCnt <= blankCnt + 8'h01;
                if (blankCnt >= 8'(BLANK_CYCLES - 1))
                    armed <= 1'b1;
            end else if (switchOn && armed && shortFlag) begin
                eventSeen <= 1'b1;
            end else if (!switchOn) begin
                armed <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Counting; one count per switching cycle at most
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= 3'h0;
        end else if (clear) begin
            count <= 3'h0;
        end else if (switchOn && armed && shortFlag && !eventSeen
                     && count != SHORT_LIMIT) begin
            count <= count + 3'h1;
        end
    end
endmodule

// ==== logic/cfps_sequencer.sv ====
// Charger fault protection sequencer top.
// Assumes async comparator flags, an externally written option word
// and a PWM cycle-start pulse from the same clock domain.
//
// What this block does
// - Battery low suspends charge for 1ms
// - After hold-off, soft start if enabled
// - Battery low: limit current, low side only refresh pulses
// - Off above 155C, resume below 135C
// - Thermal shutdown selects 16mA regulator limit
// - Bit 9 enables 18% frequency shift
// - Bit 10 picks lower or higher frequency
// - Two counters; seven shorts latch off
// - Latch cleared only by lockout or adapter
// - Low side short threshold fixed 110mV
// - Bits 8:7 choose high side threshold
// - Short flags ignored during turn-on blanking
// - Overcurrent ends high side until next cycle
`timescale 1ns/100ps
module cfps_sequencer (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // Supply and adapter status, asynchronous
    input  wire logic                       undervoltageLockout,
    input  wire logic                       adapterDetect,
    // Analog comparators, asynchronous
    input  wire logic                       batteryLowFault,
    input  wire logic                       overTemp,
    input  wire logic                       highSideShort,
    input  wire logic                       lowSideShort,
    input  wire logic                       cycleOverCurrent,
    // PWM timing, same clock
    input  wire logic                       cycleStart,
    input  wire logic                       pwmHighSide,
    input  wire logic                       pwmLowSide,
    input  wire logic                       refreshRequest,
    // Charge enable and options
    input  wire logic                       chargeEnable,
    input  wire logic [cfps_pkg::OPT_WIDTH-1:0] chargeOptions,
    // Gate drive and control outputs
    output logic                            highSideEnable,
    output logic                            lowSideEnable,
    output logic                            softStartRequest,
    output logic                            currentLimitLow,
    output logic                            regulatorLimitLow,
    output logic [1:0]                      freqTrim,
    output logic [1:0]                      highSideThreshold,
    output logic [1:0]                      lowSideThreshold,
    output logic                            latchedOff
);
    import cfps_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [6:0] syncA;
    logic [6:0] syncB;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA <= 7'h00;
            syncB <= 7'h00;
        end else begin
            syncA <= {cycleOverCurrent, lowSideShort, highSideShort,
                      overTemp, batteryLowFault, adapterDetect,
                      undervoltageLockout};
            syncB <= syncA;
        end
    end

    logic uvloS;
    logic adapterS;
    logic batLowS;
    logic overTempS;
    logic hsShortS;
    logic lsShortS;
    logic ocS;
    assign uvloS     = syncB[0];
    assign adapterS  = syncB[1];
    assign batLowS   = syncB[2];
    assign overTempS = syncB[3];
    assign hsShortS  = syncB[4];
    assign lsShortS  = syncB[5];
    assign ocS       = syncB[6];

    // ------------------------------------------------------------
    // Latch clearing condition
    // ------------------------------------------------------------
    logic latchClear;
    assign latchClear = uvloS || !adapterS;

    // ------------------------------------------------------------
    // Battery low onset
    // ------------------------------------------------------------
    // Hold-off fires on the fall below threshold, or on enabling from off while low;
    // a battery that stays low charges on, limited, once the hold-off has run out
    logic batLowPrev;
    logic batLowRise;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            batLowPrev <= 1'b0;
        else
            batLowPrev <= batLowS;
    end
    assign batLowRise = batLowS && !batLowPrev;

    // ------------------------------------------------------------
    // Short counters
    // ------------------------------------------------------------
    logic [2:0] hsCount;
    logic [2:0] lsCount;
    logic [2:0] next_total;
    always_comb begin
        next_total = 3'h0;
        if ({1'b0, hsCount} + {1'b0, lsCount} >= {1'b0, SHORT_LIMIT})
            next_total = SHORT_LIMIT;
        else
            next_total = hsCount + lsCount;
    end

    cfps_short_counter hsCounter (
        .clk       (clk),
        .rstn      (rstn),
        .clear     (latchClear),
        .switchOn  (highSideEnable),
        .shortFlag (hsShortS),
        .count     (hsCount)
    );

    cfps_short_counter lsCounter (
        .clk       (clk),
        .rstn      (rstn),
        .clear     (latchClear),
        .switchOn  (lowSideEnable),
        .shortFlag (lsShortS),
        .count     (lsCount)
    );

    // ------------------------------------------------------------
    // Main sequencer
    // ------------------------------------------------------------
    cfps_state_t state;
    logic [31:0] timer;
    logic        enablesMet;
    assign enablesMet = chargeEnable && adapterS && !uvloS;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= CFPS_OFF;
            timer <= 32'h0000_0000;
        end else begin
            timer <= timer + 32'h0000_0001;
            case (state)
                CFPS_OFF: begin
                    timer <= 32'h0000_0000;
                    if (overTempS)
                        state <= CFPS_THERMAL;
                    else if (enablesMet && batLowS)
                        state <= CFPS_HOLDOFF;
                    else if (enablesMet)
                        state <= CFPS_SOFT;
                end
                CFPS_SOFT, CFPS_RUN: begin
                    if (next_total == SHORT_LIMIT) begin
                        state <= CFPS_LATCHED;
                    end else if (overTempS) begin
                        state <= CFPS_THERMAL;
                    end else if (batLowRise) begin
                        state <= CFPS_HOLDOFF;
                        timer <= 32'h0000_0000;
                    end else if (!enablesMet) begin
                        state <= CFPS_OFF;
                    end else if (state == CFPS_SOFT &&
                                 timer >= 32'(SOFTSTART_CYCLES - 1)) begin
                        state <= CFPS_RUN;
                    end
                end
                CFPS_HOLDOFF: begin
                    if (next_total == SHORT_LIMIT) begin
                        state <= CFPS_LATCHED;
                    end else if (overTempS) begin
                        state <= CFPS_THERMAL;
                    end else if (timer >= 32'(HOLDOFF_CYCLES - 1)) begin
                        timer <= 32'h0000_0000;
                        // Resume even if still low; gates then limit
                        if (enablesMet)
                            state <= CFPS_SOFT;
                        else
                            state <= CFPS_OFF;
                    end
                end
                CFPS_THERMAL: begin
                    // Comparator carries the 155/135 hysteresis itself
                    timer <= 32'h0000_0000;
                    if (!overTempS)
                        state <= CFPS_OFF;
                end
                CFPS_LATCHED: begin
                    timer <= 32'h0000_0000;
                    if (latchClear)
                        state <= CFPS_OFF;
                end
                default: begin
                    state <= CFPS_OFF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Cycle-by-cycle overcurrent cut-off
    // ------------------------------------------------------------
    logic ocCut;
    // A trip and a cycle start together: the trip wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            ocCut <= 1'b0;
        else if (ocS)
            ocCut <= 1'b1;
        else if (cycleStart)
            ocCut <= 1'b0;
    end

    // ------------------------------------------------------------
    // Gate enables
    // ------------------------------------------------------------
    logic switching;
    assign switching = (state == CFPS_SOFT) || (state == CFPS_RUN);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            highSideEnable <= 1'b0;
        else
            // Latched, thermal and hold-off states all gate off
            highSideEnable <= switching && pwmHighSide && !ocCut
                              && !ocS;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            lowSideEnable <= 1'b0;
        else if (batLowS)
            // Only bootstrap refresh pulses in low battery
            lowSideEnable <= switching && refreshRequest
                             && !pwmHighSide;
        else
            lowSideEnable <= switching && pwmLowSide;
    end

    // ------------------------------------------------------------
    // Status and control outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            softStartRequest <= 1'b0;
            latchedOff       <= 1'b0;
        end else begin
            softStartRequest <= (state == CFPS_SOFT);
            latchedOff       <= (state == CFPS_LATCHED);
        end
    end

    // Select is a plain level; the charge loop sets the current itself
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            currentLimitLow <= 1'b0;
        else
            currentLimitLow <= batLowS;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            regulatorLimitLow <= 1'b0;
        else
            regulatorLimitLow <= (state == CFPS_THERMAL);
    end

    // ------------------------------------------------------------
    // Option decode
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            freqTrim <= FREQ_NOM;
        else if (!chargeOptions[OPT_FREQ_EN])
            freqTrim <= FREQ_NOM;
        else if (chargeOptions[OPT_FREQ_UP])
            freqTrim <= FREQ_UP;
        else
            freqTrim <= FREQ_DOWN;
    end

    // Threshold codes only; the comparators hold the analog levels
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            highSideThreshold <= 2'h0;
            lowSideThreshold  <= LS_THR_CODE;
        end else begin
            highSideThreshold <=
                chargeOptions[OPT_HS_THR_HI:OPT_HS_THR_LO];
            lowSideThreshold <= LS_THR_CODE;
        end
    end
endmodule

// ==== testbench/cfps_sequencer_props.sv ====
// Assertions on the fault sequencer top ports.
// Assumes one clock domain; bound to every sequencer instance.
`timescale 1ns/100ps
module cfps_sequencer_chk (
    // Clock and reset
    input wire logic                        clk,
    input wire logic                        rstn,
    // Watched inputs
    input wire logic                        undervoltageLockout,
    input wire logic                        adapterDetect,
    input wire logic                        batteryLowFault,
    input wire logic                        overTemp,
    input wire logic                        cycleOverCurrent,
    input wire logic                        cycleStart,
    input wire logic [cfps_pkg::OPT_WIDTH-1:0] chargeOptions,
    // Watched outputs
    input wire logic                        highSideEnable,
    input wire logic                        lowSideEnable,
    input wire logic                        softStartRequest,
    input wire logic                        currentLimitLow,
    input wire logic                        regulatorLimitLow,
    input wire logic [1:0]                  freqTrim,
    input wire logic [1:0]                  highSideThreshold,
    input wire logic [1:0]                  lowSideThreshold,
    input wire logic                        latchedOff
);
    import cfps_pkg::*;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    logic clrReq;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    assign clrReq = undervoltageLockout || !adapterDetect;
    // Three quiet edges cover up to two stages of option latency
    sequence s_optQuiet;
        $stable(chargeOptions) [*3] ##0 $past(rstn, 3);
    endsequence
    sequence s_ocHeld;
        (cycleOverCurrent && !cycleStart) [*5];
    endsequence
    property p_hsThr;
        s_optQuiet |-> highSideThreshold == chargeOptions[8:7];
    endproperty
    property p_freq;
        s_optQuiet |-> freqTrim == (!chargeOptions[OPT_FREQ_EN] ? FREQ_NOM
            : chargeOptions[OPT_FREQ_UP] ? FREQ_UP : FREQ_DOWN);
    endproperty
    property p_lsThr;
        lowSideThreshold == LS_THR_CODE;
    endproperty
    property p_latchGates;
        latchedOff && $past(latchedOff) |->
            !highSideEnable && !lowSideEnable && !softStartRequest;
    endproperty
    property p_latchClr;
        $fell(latchedOff) |->
            $past(clrReq, 2) || $past(clrReq, 3) || $past(clrReq, 4);
    endproperty
    property p_thermal;
        (overTemp && !latchedOff) [*5] |-> regulatorLimitLow;
    endproperty
    property p_thermalOff;
        regulatorLimitLow && $past(regulatorLimitLow) |->
            !highSideEnable && !lowSideEnable;
    endproperty
    property p_ocCut;
        s_ocHeld |-> !highSideEnable;
    endproperty
    property p_batLow;
        $stable(batteryLowFault) [*5] |-> currentLimitLow == batteryLowFault;
    endproperty
    a_hsThr: assert property (p_hsThr) else $error("hs threshold");
    a_freq: assert property (p_freq) else $error("freq trim");
    a_lsThr: assert property (p_lsThr) else $error("ls threshold");
    a_latchGates: assert property (p_latchGates) else $error("gates");
    a_latchClr: assert property (p_latchClr) else $error("latch clr");
    a_thermal: assert property (p_thermal) else $error("thermal");
    a_thermalOff: assert property (p_thermalOff) else $error("off");
    a_ocCut: assert property (p_ocCut) else $error("overcurrent");
    a_batLow: assert property (p_batLow) else $error("bat low");
endmodule

bind cfps_sequencer cfps_sequencer_chk i_chk (
    .clk, .rstn, .undervoltageLockout, .adapterDetect, .batteryLowFault,
    .overTemp, .cycleOverCurrent, .cycleStart, .chargeOptions,
    .highSideEnable, .lowSideEnable, .softStartRequest, .currentLimitLow,
    .regulatorLimitLow, .freqTrim, .highSideThreshold, .lowSideThreshold,
    .latchedOff
);

// ==== testbench/cfps_power_stage.sv ====
// Power stage model: PWM timing and short comparators.
// Assumes gate enables from the sequencer on the same clock.
`timescale 1ns/100ps
module cfps_power_stage (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Short mode: 0 none, 1 early both, 2 late high, 3 late both
    input  wire logic [1:0] shortMode,
    // Gate enables
    input  wire logic       highSideEnable,
    input  wire logic       lowSideEnable,
    // PWM and comparators
    output logic            cycleStart,
    output logic            pwmHighSide,
    output logic            pwmLowSide,
    output logic            refreshRequest,
    output logic            highSideShort,
    output logic            lowSideShort
);
    int phase;
    int hsOn;
    int lsOn;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase <= 0;
            hsOn <= 0;
            lsOn <= 0;
        end else begin
            phase <= (phase == 19) ? 0 : phase + 1;
            hsOn <= highSideEnable ? hsOn + 1 : 0;
            lsOn <= lowSideEnable ? lsOn + 1 : 0;
        end
    end
    // Dead phases 0 and 9 keep the two switches apart
    assign cycleStart = (phase == 0);
    assign pwmHighSide = (phase >= 1 && phase <= 8);
    assign pwmLowSide = (phase >= 10);
    assign refreshRequest = (phase == 14 || phase == 15);
    // Flags only while the switch conducts
    // High side conducts only eight cycles, so its late flag starts sooner
    assign highSideShort = highSideEnable &&
        (shortMode == 2'h1 ? hsOn < 3 : shortMode[1] && hsOn >= 4);
    assign lowSideShort = lowSideEnable &&
        (shortMode == 2'h1 ? lsOn < 3 : shortMode == 2'h3 && lsOn >= 6);
endmodule

// ==== testbench/test_charger_fault_protection_sequencer.sv ====
// Self-checking bench for the fault sequencer.
// Assumes the power stage model and bound checker are compiled.
`timescale 1ns/100ps
module test_charger_fault_protection_sequencer;
    import cfps_pkg::*;
    logic clk = 0, rstn = 0, undervoltageLockout = 0, adapterDetect = 1;
    logic batteryLowFault = 0, overTemp = 0, cycleOverCurrent = 0;
    logic chargeEnable = 0, cycleStart, pwmHighSide, pwmLowSide;
    logic refreshRequest, highSideShort, lowSideShort, highSideEnable;
    logic lowSideEnable, softStartRequest, currentLimitLow, latchedOff;
    logic regulatorLimitLow;
    logic [1:0] shortMode = 0, freqTrim, highSideThreshold, lowSideThreshold;
    logic [15:0] chargeOptions = 0;
    logic [1:0] plan[$] = '{1, 1, 3, 3, 3, 2, 0};
    int errorCnt = 0, testsRun = 0, n, cnt;
    cfps_sequencer i_cfps_sequencer (
        .clk, .rstn, .undervoltageLockout, .adapterDetect,
        .batteryLowFault, .overTemp, .highSideShort, .lowSideShort,
        .cycleOverCurrent, .cycleStart, .pwmHighSide, .pwmLowSide,
        .refreshRequest, .chargeEnable, .chargeOptions, .highSideEnable,
        .lowSideEnable, .softStartRequest, .currentLimitLow,
        .regulatorLimitLow, .freqTrim, .highSideThreshold,
        .lowSideThreshold, .latchedOff);
    cfps_power_stage i_cfps_power_stage (
        .clk, .rstn, .shortMode, .highSideEnable, .lowSideEnable,
        .cycleStart, .pwmHighSide, .pwmLowSide, .refreshRequest,
        .highSideShort, .lowSideShort);
    always #10 clk = ~clk;
    // ------------------------------------------------------------
    // Tasks and model
    // ------------------------------------------------------------
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic waitSoft(logic lvl, int lim, output int k);
        for (k = 0; k < lim && softStartRequest !== lvl; k++) tick(1);
        if (softStartRequest !== lvl) errorCnt++;
    endtask
    task automatic waitStart();
        for (int k = 0; k < 25 && cycleStart !== 1'b1; k++) tick(1);
        if (cycleStart !== 1'b1) errorCnt++;
    endtask
    function automatic logic [1:0] expFreq(logic [15:0] o);
        if (!o[9]) return FREQ_NOM;
        return o[10] ? FREQ_UP : FREQ_DOWN;
    endfunction
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Holdoff alone is 50000 cycles, so the limit sits above it
    initial begin
        #(70000 * 20);
        errorCnt++;
        wrapUp();
    end
    initial begin
        void'($urandom(92621));
        tick(3);
        chk({highSideEnable, lowSideEnable, softStartRequest}, 0);
        chk(16'(latchedOff), 0);
        tick(2);
        rstn = 1;
        for (int i = 0; i < 16; i++) begin
            chargeOptions = 16'($urandom) & 16'hF87F | 16'(i << 7);
            tick(5);
            chk(16'(freqTrim), 16'(expFreq(chargeOptions)));
            chk(16'(highSideThreshold), 16'(i[1:0]));
            chk(16'(lowSideThreshold), 16'(LS_THR_CODE));
        end
        chargeEnable = 1;
        waitSoft(1, 20, n);
        chk(16'(softStartRequest), 1);
        waitSoft(0, 600, n);
        waitStart();
        tick(2);
        cycleOverCurrent = 1;
        tick(5);
        cycleOverCurrent = 0;
        chk(16'(highSideEnable), 0);
        waitStart();
        tick(4);
        chk(16'(highSideEnable), 1);
        cnt = 0;
        foreach (plan[k]) begin
            waitStart();
            shortMode = plan[k];
            tick(5);
            chk(16'(latchedOff), 16'(cnt >= 7));
            cnt += int'(plan[k] >= 2) + int'(plan[k] == 3);
        end
        tick(60);
        chk({highSideEnable, lowSideEnable, softStartRequest}, 0);
        adapterDetect = 0;
        tick(8);
        chk(16'(latchedOff), 0);
        adapterDetect = 1;
        waitSoft(1, 40, n);
        chk(16'(softStartRequest), 1);
        overTemp = 1;
        tick(8);
        chk(16'(regulatorLimitLow), 1);
        chk({highSideEnable, lowSideEnable}, 0);
        overTemp = 0;
        waitSoft(1, 30, n);
        chk({softStartRequest, regulatorLimitLow}, 2);
        waitSoft(0, 600, n);
        batteryLowFault = 1;
        tick(20);
        chk(16'(currentLimitLow), 1);
        // Battery stays low: hold-off, then a limited soft start
        waitSoft(1, HOLDOFF_CYCLES + 100, n);
        n -= HOLDOFF_CYCLES - 20;
        chk(16'(n >= 0 && n <= 8), 1);
        cnt = 0;
        for (int k = 0; k < 40; k++) begin
            cnt += int'(lowSideEnable);
            tick(1);
        end
        // Stage model asks two refresh cycles in every period of 20
        chk(16'(cnt), 16'h0004);
        batteryLowFault = 0;
        tick(4);
        chk(16'(currentLimitLow), 0);
        wrapUp();
    end
endmodule
